// ---- common/mdsr_pkg.sv ----
/*
 * package for the motion drive state register bank: operand selectors,
 * fault and status codes, widths, reset values.
 * assumes one sys_clk domain and that the sequence interpreter uses these codes.
 */
package mdsr_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int unsigned DATA_W = 32;
	localparam int unsigned PIN_W = 8;
	localparam int unsigned UVAR_N = 16;
	localparam int unsigned UVAR_AW = 4;

	// ****************************************
	// operand selectors
	// ****************************************
	typedef enum logic [4:0] {
		MDSR_OP_VELOCITY,
		MDSR_OP_FAULT,
		MDSR_OP_FEEDBACK,
		MDSR_OP_INPUT,
		MDSR_OP_OUTPUT,
		MDSR_OP_POSITION,
		MDSR_OP_STATUS,
		MDSR_OP_TARGET_VEL,
		MDSR_OP_IMMEDIATE,
		MDSR_OP_UVAR
	} mdsr_op_t;

	// ****************************************
	// fault codes
	// ****************************************
	localparam logic [7:0] FAULT_OVERVOLT = 8'h01;
	localparam logic [7:0] FAULT_SHORT = 8'h02;
	localparam logic [7:0] FAULT_CCW_LIMIT = 8'h04;
	localparam logic [7:0] FAULT_CW_LIMIT = 8'h08;

	// ****************************************
	// status codes; 10 and 20 taken as hexadecimal, one bit each
	// ****************************************
	localparam logic [7:0] STAT_SLEW = 8'h01;
	localparam logic [7:0] STAT_MOVING = 8'h02;
	localparam logic [7:0] STAT_IN_DELAY = 8'h04;
	localparam logic [7:0] STAT_STOP_IN = 8'h08;
	localparam logic [7:0] STAT_DISABLED = 8'h10;
	localparam logic [7:0] STAT_SEQ_RUN = 8'h20;

	// ****************************************
	// scale and reset values, access error codes
	// ****************************************
	localparam int unsigned USTEP_PER_REV = 12800;
	localparam int unsigned MINISTEP_PER_REV = 83886;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [1:0] ERR_NONE = 2'h0;
	localparam logic [1:0] ERR_RO_WRITE = 2'h1;
	localparam logic [1:0] ERR_IMM_OP1 = 2'h2;

endpackage : mdsr_pkg

// ---- common/mdsr_uvar_if.sv ----
/*
 * interface between the register bank and its user variable store.
 * assumes both ends run on the one sys_clk.
 */
`timescale 1ns/10ps
interface mdsr_uvar_if;
	logic we;
	logic [mdsr_pkg::UVAR_AW-1:0] waddr;
	logic [mdsr_pkg::DATA_W-1:0] wdata;
	logic [mdsr_pkg::UVAR_AW-1:0] raddr;
	logic [mdsr_pkg::DATA_W-1:0] rdata;

	modport bank (output we, output waddr, output wdata, output raddr, input rdata);
	modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : mdsr_uvar_if

// ---- core/mdsr_uvar_store.sv ----
/*
 * user variable store: flip-flop array indexed by variable number.
 * assumes resetn covers both drive reset and power loss.
 */
`timescale 1ns/10ps
module mdsr_uvar_store (
	input wire logic sys_clk,
	input wire logic resetn,
	mdsr_uvar_if.store port
);
	logic [mdsr_pkg::DATA_W-1:0] var_q [mdsr_pkg::UVAR_N];

	// ****************************************
	// storage, one entry per variable
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < mdsr_pkg::UVAR_N; gi++) begin : g_var
			// reset clears every variable, nothing survives a reset
			always_ff @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					var_q[gi] <= mdsr_pkg::RST_WORD;
				end else if (port.we && int'(port.waddr) == gi) begin
					var_q[gi] <= port.wdata;
				end
			end
		end
	endgenerate

	// combinational read, the bank registers the result
	assign port.rdata = var_q[port.raddr];

endmodule : mdsr_uvar_store

// ---- core/mdsr_bank.sv ----
/*
 * motion drive state register bank: operands read and written by the
 * sequence interpreter when an instruction executes.
 * assumes the interpreter presents one access per cycle, synchronous to sys_clk,
 * and that drive state inputs are already synchronous.
 */
// Notes on behaviour
// - present velocity sampled at execution, read only
// - fault register sampled at execution, read only, for comparisons
// - fault codes: overvoltage 1, short 2, ccw limit 4, cw limit 8
// - feedback count readable at execution and writable by arithmetic
// - input pin image sampled at execution, read only
// - input n sits at bit n-1 of the input image
// - output image equals present output states, read only
// - output n sits at bit n-1 of the output image
// - commanded position readable and writable, redefines present position
// - position counts microsteps, 12800 per revolution
// - status register sampled at execution, read only
// - status 1 at slew, 2 while moving
// - status 4 while a wait delay executes
// - status 8 when halted by stop input
// - status 10 when disabled through enable input
// - status 20 while a sequence executes
// - target velocity holds last set value, set command or arithmetic
// - target velocity in ministeps per second, 83886 per revolution
// - immediate constant allowed only as second operand
// - user variables cleared on reset or power loss
`timescale 1ns/10ps
module mdsr_bank (
	input wire logic sys_clk,
	input wire logic resetn,
	// interpreter read port
	input wire logic rd_en,
	input wire mdsr_pkg::mdsr_op_t rd_op1,
	input wire mdsr_pkg::mdsr_op_t rd_op2,
	input wire logic [mdsr_pkg::UVAR_AW-1:0] rd_var1,
	input wire logic [mdsr_pkg::UVAR_AW-1:0] rd_var2,
	input wire logic [mdsr_pkg::DATA_W-1:0] rd_imm,
	output logic [mdsr_pkg::DATA_W-1:0] rd_data1,
	output logic [mdsr_pkg::DATA_W-1:0] rd_data2,
	output logic rd_valid,
	// interpreter write port
	input wire logic wr_en,
	input wire mdsr_pkg::mdsr_op_t wr_op,
	input wire logic [mdsr_pkg::UVAR_AW-1:0] wr_var,
	input wire logic [mdsr_pkg::DATA_W-1:0] wr_data,
	input wire logic set_vel_en,
	input wire logic [mdsr_pkg::DATA_W-1:0] set_vel_data,
	output logic [1:0] acc_err,
	// drive state
	input wire logic [mdsr_pkg::DATA_W-1:0] cur_velocity,
	input wire logic enc_inc,
	input wire logic enc_dec,
	input wire logic ustep_inc,
	input wire logic ustep_dec,
	input wire logic fault_overvolt,
	input wire logic fault_short,
	input wire logic fault_ccw_limit,
	input wire logic fault_cw_limit,
	input wire logic [mdsr_pkg::PIN_W-1:0] in_pins,
	input wire logic [mdsr_pkg::PIN_W-1:0] out_pins,
	input wire logic at_slew,
	input wire logic moving,
	input wire logic in_delay,
	input wire logic stop_halt,
	input wire logic enable_off,
	input wire logic seq_run,
	// held registers out to the motion logic
	output logic [mdsr_pkg::DATA_W-1:0] position,
	output logic [mdsr_pkg::DATA_W-1:0] feedback,
	output logic [mdsr_pkg::DATA_W-1:0] target_vel
);
	// ****************************************
	// declarations
	// ****************************************
	logic [mdsr_pkg::DATA_W-1:0] position_q;
	logic [mdsr_pkg::DATA_W-1:0] feedback_q;
	logic [mdsr_pkg::DATA_W-1:0] target_vel_q;
	logic [mdsr_pkg::DATA_W-1:0] rd_data1_q;
	logic [mdsr_pkg::DATA_W-1:0] rd_data2_q;
	logic [mdsr_pkg::DATA_W-1:0] rd_data1_d;
	logic [mdsr_pkg::DATA_W-1:0] rd_data2_d;
	logic rd_valid_q;
	logic [1:0] acc_err_q;
	logic [1:0] acc_err_d;
	logic [7:0] fault_now;
	logic [7:0] status_now;
	logic wr_pos;
	logic wr_fb;
	logic wr_tv;
	logic [mdsr_pkg::DATA_W-1:0] uvar_rdata1;

	mdsr_uvar_if uv ();

	mdsr_uvar_store u_store (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.port(uv.store)
	);

	// ****************************************
	// live fault and status images
	// ****************************************
	// each condition owns one bit so overlaps simply OR together
	always_comb begin
		fault_now = 8'h00;
		if (fault_overvolt) fault_now = fault_now | mdsr_pkg::FAULT_OVERVOLT;
		if (fault_short) fault_now = fault_now | mdsr_pkg::FAULT_SHORT;
		if (fault_ccw_limit) fault_now = fault_now | mdsr_pkg::FAULT_CCW_LIMIT;
		if (fault_cw_limit) fault_now = fault_now | mdsr_pkg::FAULT_CW_LIMIT;
	end

	// status codes 10 and 20 read as hex so every flag stays one bit
	always_comb begin
		status_now = 8'h00;
		if (at_slew) status_now = status_now | mdsr_pkg::STAT_SLEW;
		if (moving) status_now = status_now | mdsr_pkg::STAT_MOVING;
		if (in_delay) status_now = status_now | mdsr_pkg::STAT_IN_DELAY;
		if (stop_halt) status_now = status_now | mdsr_pkg::STAT_STOP_IN;
		if (enable_off) status_now = status_now | mdsr_pkg::STAT_DISABLED;
		if (seq_run) status_now = status_now | mdsr_pkg::STAT_SEQ_RUN;
	end

	// ****************************************
	// write decode
	// ****************************************
	// only position, feedback, target velocity and user variables take writes
	assign wr_pos = wr_en && wr_op == mdsr_pkg::MDSR_OP_POSITION;
	assign wr_fb = wr_en && wr_op == mdsr_pkg::MDSR_OP_FEEDBACK;
	assign wr_tv = wr_en && wr_op == mdsr_pkg::MDSR_OP_TARGET_VEL;
	assign uv.we = wr_en && wr_op == mdsr_pkg::MDSR_OP_UVAR;
	assign uv.waddr = wr_var;
	assign uv.wdata = wr_data;
	assign uv.raddr = rd_var1;
	assign uvar_rdata1 = uv.rdata;

	// ****************************************
	// position counter, microsteps
	// ****************************************
	// a write redefines position and wins over a step in the same cycle
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			position_q <= mdsr_pkg::RST_WORD;
		end else if (wr_pos) begin
			position_q <= wr_data;
		end else if (ustep_inc && !ustep_dec) begin
			position_q <= position_q + 32'h0000_0001;
		end else if (ustep_dec && !ustep_inc) begin
			position_q <= position_q - 32'h0000_0001;
		end
	end

	// ****************************************
	// encoder feedback counter
	// ****************************************
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			feedback_q <= mdsr_pkg::RST_WORD;
		end else if (wr_fb) begin
			feedback_q <= wr_data;
		end else if (enc_inc && !enc_dec) begin
			feedback_q <= feedback_q + 32'h0000_0001;
		end else if (enc_dec && !enc_inc) begin
			feedback_q <= feedback_q - 32'h0000_0001;
		end
	end

	// ****************************************
	// target velocity, ministeps per second
	// ****************************************
	// arithmetic write takes priority over set-velocity in the same cycle
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			target_vel_q <= mdsr_pkg::RST_WORD;
		end else if (wr_tv) begin
			target_vel_q <= wr_data;
		end else if (set_vel_en) begin
			target_vel_q <= set_vel_data;
		end
	end

	// ****************************************
	// operand read mux
	// ****************************************
	// second operand has no user variable port; that is limited to operand 1
	function automatic logic [mdsr_pkg::DATA_W-1:0] sel_op(
		input mdsr_pkg::mdsr_op_t op,
		input logic [mdsr_pkg::DATA_W-1:0] imm,
		input logic [mdsr_pkg::DATA_W-1:0] uvar,
		input logic [mdsr_pkg::DATA_W-1:0] vel,
		input logic [7:0] flt,
		input logic [mdsr_pkg::DATA_W-1:0] fb,
		input logic [mdsr_pkg::PIN_W-1:0] inp,
		input logic [mdsr_pkg::PIN_W-1:0] outp,
		input logic [mdsr_pkg::DATA_W-1:0] pos,
		input logic [7:0] st,
		input logic [mdsr_pkg::DATA_W-1:0] tv
	);
		logic [mdsr_pkg::DATA_W-1:0] r;
		r = mdsr_pkg::RST_WORD;
		case (op)
			mdsr_pkg::MDSR_OP_VELOCITY: r = vel;
			mdsr_pkg::MDSR_OP_FAULT: r = {24'h00_0000, flt};
			mdsr_pkg::MDSR_OP_FEEDBACK: r = fb;
			mdsr_pkg::MDSR_OP_INPUT: r = {24'h00_0000, inp};
			mdsr_pkg::MDSR_OP_OUTPUT: r = {24'h00_0000, outp};
			mdsr_pkg::MDSR_OP_POSITION: r = pos;
			mdsr_pkg::MDSR_OP_STATUS: r = {24'h00_0000, st};
			mdsr_pkg::MDSR_OP_TARGET_VEL: r = tv;
			mdsr_pkg::MDSR_OP_IMMEDIATE: r = imm;
			mdsr_pkg::MDSR_OP_UVAR: r = uvar;
			default: r = mdsr_pkg::RST_WORD;
		endcase
		return r;
	endfunction : sel_op

	// pin bit n-1 is input or output n, passed straight through
	always_comb begin
		rd_data1_d = sel_op(rd_op1, mdsr_pkg::RST_WORD, uvar_rdata1, cur_velocity, fault_now,
			feedback_q, in_pins, out_pins, position_q, status_now, target_vel_q);
		rd_data2_d = sel_op(rd_op2, rd_imm, mdsr_pkg::RST_WORD, cur_velocity, fault_now,
			feedback_q, in_pins, out_pins, position_q, status_now, target_vel_q);
		if (rd_op1 == mdsr_pkg::MDSR_OP_IMMEDIATE) begin
			rd_data1_d = mdsr_pkg::RST_WORD;
		end
	end

	// ****************************************
	// access error check
	// ****************************************
	// refused writes leave every register unchanged
	always_comb begin
		acc_err_d = mdsr_pkg::ERR_NONE;
		if (rd_en && rd_op1 == mdsr_pkg::MDSR_OP_IMMEDIATE) begin
			acc_err_d = mdsr_pkg::ERR_IMM_OP1;
		end else if (wr_en && !(wr_pos || wr_fb || wr_tv || uv.we)) begin
			acc_err_d = mdsr_pkg::ERR_RO_WRITE;
		end
	end

	// ****************************************
	// sampled read results
	// ****************************************
	// values captured on the execute edge, held until the next read
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rd_data1_q <= mdsr_pkg::RST_WORD;
			rd_data2_q <= mdsr_pkg::RST_WORD;
		end else if (rd_en) begin
			rd_data1_q <= rd_data1_d;
			rd_data2_q <= rd_data2_d;
		end
	end

	// one-cycle valid and error flags
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rd_valid_q <= 1'b0;
			acc_err_q <= mdsr_pkg::ERR_NONE;
		end else begin
			rd_valid_q <= rd_en;
			acc_err_q <= acc_err_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign rd_data1 = rd_data1_q;
	assign rd_data2 = rd_data2_q;
	assign rd_valid = rd_valid_q;
	assign acc_err = acc_err_q;
	assign position = position_q;
	assign feedback = feedback_q;
	assign target_vel = target_vel_q;

endmodule : mdsr_bank

// ---- tb/mdsr_bank_properties.sv ----
/* checker for mdsr_bank: concurrent properties on its top ports.
 * assumes the bench binds it into mdsr_bank by name. */
`timescale 1ns/10ps
module mdsr_bank_properties (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic rd_en,
	input wire mdsr_pkg::mdsr_op_t rd_op1,
	input wire mdsr_pkg::mdsr_op_t rd_op2,
	input wire logic [31:0] rd_imm,
	input wire logic [31:0] rd_data1,
	input wire logic [31:0] rd_data2,
	input wire logic rd_valid,
	input wire logic [1:0] acc_err,
	input wire logic wr_en,
	input wire mdsr_pkg::mdsr_op_t wr_op,
	input wire logic [31:0] wr_data,
	input wire logic set_vel_en,
	input wire logic [31:0] set_vel_data,
	input wire logic [7:0] in_pins,
	input wire logic [31:0] position,
	input wire logic [31:0] feedback,
	input wire logic [31:0] target_vel
);
	// ****************
	// one clock, one reset for all checks
	// ****************
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	// read answer timing and hold
	rd_valid_a: assert property (rd_valid == $past(rd_en))
		else $error("read answer not one cycle after request");
	data_hold_a: assert property (!rd_en |=> $stable(rd_data1) && $stable(rd_data2))
		else $error("read data changed without a read");
	// input n lands on bit n-1, zero above
	in_image_a: assert property (rd_en && rd_op1 == mdsr_pkg::MDSR_OP_INPUT
		|=> rd_data1 == 32'($past(in_pins)))
		else $error("input image wrong");
	imm_second_a: assert property (rd_en && rd_op2 == mdsr_pkg::MDSR_OP_IMMEDIATE
		|=> rd_data2 == $past(rd_imm))
		else $error("immediate operand 2 wrong");
	imm_first_a: assert property (rd_en && rd_op1 == mdsr_pkg::MDSR_OP_IMMEDIATE
		|=> acc_err == mdsr_pkg::ERR_IMM_OP1 && rd_data1 == 32'h0000_0000)
		else $error("immediate operand 1 not refused");
	// writes land one cycle later and beat counter steps
	pos_write_a: assert property (wr_en && wr_op == mdsr_pkg::MDSR_OP_POSITION
		|=> position == $past(wr_data))
		else $error("position write lost");
	fb_write_a: assert property (wr_en && wr_op == mdsr_pkg::MDSR_OP_FEEDBACK
		|=> feedback == $past(wr_data))
		else $error("feedback write lost");
	set_vel_a: assert property (set_vel_en && !(wr_en && wr_op == mdsr_pkg::MDSR_OP_TARGET_VEL)
		|=> target_vel == $past(set_vel_data))
		else $error("set velocity lost");
	tv_hold_a: assert property (!set_vel_en && !wr_en |=> $stable(target_vel))
		else $error("target velocity moved by itself");

	// main scenarios reached
	cover property (rd_en && rd_op1 == mdsr_pkg::MDSR_OP_STATUS);
	cover property (acc_err == mdsr_pkg::ERR_RO_WRITE);
	cover property (set_vel_en && wr_en);
endmodule : mdsr_bank_properties

// ---- tb/mdsr_bank_tb.sv ----
/* self-checking bench for mdsr_bank, driving all ports directly.
 * assumes mdsr_pkg and the checker are compiled first. */
`timescale 1ns/10ps
module mdsr_bank_tb;
	logic sys_clk = 1'b0, resetn = 1'b0, rd_en = 1'b0, wr_en = 1'b0, set_vel_en = 1'b0;
	logic enc_inc = 1'b0, enc_dec = 1'b0, ustep_inc = 1'b0, ustep_dec = 1'b0, rd_valid;
	mdsr_pkg::mdsr_op_t rd_op1 = mdsr_pkg::MDSR_OP_VELOCITY, rd_op2 = mdsr_pkg::MDSR_OP_VELOCITY;
	mdsr_pkg::mdsr_op_t wr_op = mdsr_pkg::MDSR_OP_POSITION;
	logic [3:0] rd_var1 = '0, wr_var = '0, flt = '0;
	logic [31:0] rd_imm = '0, wr_data = '0, set_vel_data = '0, cur_velocity = '0;
	logic [31:0] rd_data1, rd_data2, position, feedback, target_vel;
	logic [7:0] in_pins = '0, out_pins = '0;
	logic [5:0] st = '0;
	logic [1:0] acc_err;
	int err_total = 0, comparisons = 0;

	mdsr_bank i_dut (.sys_clk, .resetn, .rd_en, .rd_op1, .rd_op2, .rd_var1, .rd_var2(4'h0),
		.rd_imm, .rd_data1, .rd_data2, .rd_valid, .wr_en, .wr_op, .wr_var, .wr_data,
		.set_vel_en, .set_vel_data, .acc_err, .cur_velocity, .enc_inc, .enc_dec,
		.ustep_inc, .ustep_dec, .fault_overvolt(flt[0]), .fault_short(flt[1]),
		.fault_ccw_limit(flt[2]), .fault_cw_limit(flt[3]), .in_pins, .out_pins,
		.at_slew(st[0]), .moving(st[1]), .in_delay(st[2]), .stop_halt(st[3]),
		.enable_off(st[4]), .seq_run(st[5]), .position, .feedback, .target_vel);

	// ****************
	// shared tasks
	// ****************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask : chk
	// inputs always move 2 ns after the edge
	task automatic step();
		@(posedge sys_clk);
		#2;
	endtask : step
	// one read, judged in the single answer cycle
	task automatic rd(input mdsr_pkg::mdsr_op_t o1, input mdsr_pkg::mdsr_op_t o2,
		input logic [31:0] imm, input logic [31:0] e1, input logic [31:0] e2);
		rd_en = 1'b1;
		rd_op1 = o1;
		rd_op2 = o2;
		rd_imm = imm;
		step();
		rd_en = 1'b0;
		chk(32'(rd_valid), 32'h0000_0001);
		chk(rd_data1, e1);
		chk(rd_data2, e2);
		chk(32'(acc_err), (o1 == mdsr_pkg::MDSR_OP_IMMEDIATE) ? 32'h0000_0002 : 32'h0000_0000);
		step();
	endtask : rd
	task automatic wr(input mdsr_pkg::mdsr_op_t op, input logic [3:0] v,
		input logic [31:0] d, input logic [1:0] e_err);
		wr_en = 1'b1;
		wr_op = op;
		wr_var = v;
		wr_data = d;
		step();
		wr_en = 1'b0;
		chk(32'(acc_err), 32'(e_err));
		step();
	endtask : wr

	// ****************
	// scenarios
	// ****************
	task automatic t_codes();
		logic [7:0] sc [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20};
		for (int i = 0; i < 4; i++) begin
			flt = 4'h1 << i;
			rd(mdsr_pkg::MDSR_OP_FAULT, mdsr_pkg::MDSR_OP_STATUS, '0, 32'(sc[i]), '0);
		end
		flt = 4'hf;
		rd(mdsr_pkg::MDSR_OP_FAULT, mdsr_pkg::MDSR_OP_STATUS, '0, 32'h0000_000f, '0);
		for (int i = 0; i < 6; i++) begin
			st = 6'h01 << i;
			rd(mdsr_pkg::MDSR_OP_STATUS, mdsr_pkg::MDSR_OP_FAULT, '0, 32'(sc[i]), 32'h0000_000f);
		end
		st = 6'h3f;
		rd(mdsr_pkg::MDSR_OP_STATUS, mdsr_pkg::MDSR_OP_FAULT, '0, 32'h0000_003f, 32'h0000_000f);
	endtask : t_codes
	task automatic t_fixed();
		cur_velocity = 32'h1234_5678;
		in_pins = 8'h0a;
		out_pins = 8'h06;
		rd(mdsr_pkg::MDSR_OP_VELOCITY, mdsr_pkg::MDSR_OP_INPUT, '0, 32'h1234_5678, 32'h0000_000a);
		// input image as first operand, so the bit placement check sees it
		rd(mdsr_pkg::MDSR_OP_INPUT, mdsr_pkg::MDSR_OP_OUTPUT, '0, 32'h0000_000a,
			32'h0000_0006);
		rd(mdsr_pkg::MDSR_OP_OUTPUT, mdsr_pkg::MDSR_OP_IMMEDIATE, 32'h0000_0002, 32'h0000_0006, 32'h0000_0002);
		rd(mdsr_pkg::MDSR_OP_IMMEDIATE, mdsr_pkg::MDSR_OP_VELOCITY, 32'h0000_0002, '0, 32'h1234_5678);
	endtask : t_fixed
	task automatic t_write();
		mdsr_pkg::mdsr_op_t ro [6] = '{mdsr_pkg::MDSR_OP_VELOCITY, mdsr_pkg::MDSR_OP_FAULT,
			mdsr_pkg::MDSR_OP_INPUT, mdsr_pkg::MDSR_OP_OUTPUT, mdsr_pkg::MDSR_OP_STATUS,
			mdsr_pkg::MDSR_OP_IMMEDIATE};
		wr(mdsr_pkg::MDSR_OP_POSITION, 4'h0, 32'h0000_3200, 2'h0);
		chk(position, 32'h0000_3200);
		wr(mdsr_pkg::MDSR_OP_FEEDBACK, 4'h0, 32'h0000_2ee0, 2'h0);
		chk(feedback, 32'h0000_2ee0);
		ustep_inc = 1'b1;
		enc_dec = 1'b1;
		step();
		ustep_inc = 1'b0;
		enc_dec = 1'b0;
		chk(position, 32'h0000_3201);
		chk(feedback, 32'h0000_2edf);
		foreach (ro[i]) begin
			wr(ro[i], 4'h0, 32'h0000_0000, 2'h1);
			chk(position, 32'h0000_3201);
		end
		set_vel_en = 1'b1;
		set_vel_data = 32'h0001_47ae;
		step();
		set_vel_en = 1'b0;
		chk(target_vel, 32'h0001_47ae);
		step();
		// arithmetic write and set command in one cycle: write must win
		set_vel_en = 1'b1;
		set_vel_data = '0;
		wr_en = 1'b1;
		wr_op = mdsr_pkg::MDSR_OP_TARGET_VEL;
		wr_data = 32'h0013_3332;
		step();
		set_vel_en = 1'b0;
		wr_en = 1'b0;
		chk(target_vel, 32'h0013_3332);
		step();
		// held registers must also come back through the operand path
		rd(mdsr_pkg::MDSR_OP_POSITION, mdsr_pkg::MDSR_OP_FEEDBACK, '0, 32'h0000_3201,
			32'h0000_2edf);
		rd(mdsr_pkg::MDSR_OP_TARGET_VEL, mdsr_pkg::MDSR_OP_IMMEDIATE, 32'h0000_000f,
			32'h0013_3332, 32'h0000_000f);
	endtask : t_write
	task automatic t_uvar();
		wr(mdsr_pkg::MDSR_OP_UVAR, 4'h3, 32'h0000_0005, 2'h0);
		rd_var1 = 4'h3;
		rd(mdsr_pkg::MDSR_OP_UVAR, mdsr_pkg::MDSR_OP_IMMEDIATE, 32'h0000_0007, 32'h0000_0005,
			32'h0000_0007);
		resetn = 1'b0;
		step();
		resetn = 1'b1;
		rd(mdsr_pkg::MDSR_OP_UVAR, mdsr_pkg::MDSR_OP_IMMEDIATE, '0, '0, '0);
		chk(position, '0);
	endtask : t_uvar

	task automatic conclude();
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude

	// clock, main sequence, watchdog
	initial forever #12.5 sys_clk = ~sys_clk;
	initial begin
		repeat (8) @(posedge sys_clk);
		#2;
		resetn = 1'b1;
		t_codes();
		t_fixed();
		t_write();
		t_uvar();
		conclude();
	end
	initial begin
		#100us;
		err_total++;
		conclude();
	end
endmodule : mdsr_bank_tb

bind mdsr_bank mdsr_bank_properties i_props (.sys_clk, .resetn, .rd_en, .rd_op1,
	.rd_op2, .rd_imm, .rd_data1, .rd_data2, .rd_valid, .acc_err, .wr_en, .wr_op,
	.wr_data, .set_vel_en, .set_vel_data, .in_pins, .position, .feedback, .target_vel);
